// File: hdl/tmr_regs.vh
`ifndef TMR_REGS_VH
`define TMR_REGS_VH
// ----------------------------------------
// Register word indexes
// ----------------------------------------
`define TMR_IDX_FLAG         8'h0C
`define TMR_IDX_COUNT_LOW    8'h0E
`define TMR_IDX_COUNT_HIGH   8'h0F
`define TMR_IDX_CONTROL      8'h10
`define TMR_IDX_ENABLE       8'h8C
// ----------------------------------------
// Register byte addresses, four times the index
// ----------------------------------------
`define TMR_ADDR_FLAG        10'h030
`define TMR_ADDR_COUNT_LOW   10'h038
`define TMR_ADDR_COUNT_HIGH  10'h03C
`define TMR_ADDR_CONTROL     10'h040
`define TMR_ADDR_ENABLE      10'h230
// ----------------------------------------
// Control register fields and reset value
// ----------------------------------------
`define TMR_CTL_RUN          0
`define TMR_CTL_SRC          1
`define TMR_CTL_SYNC         2
`define TMR_CTL_OSCEN        3
`define TMR_CTL_PS_LO        4
`define TMR_CTL_PS_HI        5
`define TMR_CTL_RESET        6'h00
`define TMR_CTL_MASK         8'h3F
// ----------------------------------------
// Flag / enable bit positions
// ----------------------------------------
`define TMR_OVF_BIT          0
`define TMR_IE_BIT           0
// ----------------------------------------
// Timing: instruction cycle = 4 oscillator periods
// ----------------------------------------
`define TMR_PHASES           4
`define TMR_MAX_COUNT        16'hFFFF
`define TMR_ZERO_COUNT       16'h0000
`endif

// File: hdl/tmr_timer1.v
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/100ps
`include "tmr_regs.vh"

module tmr_timer1
(
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        por_resetn,
	input  wire        hsel,
	input  wire [9:0]  haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	input  wire        osc_input_pin,
	input  wire        ext_clock_pin,
	input  wire        sleep_mode,
	input  wire        compare_trigger_a,
	input  wire        compare_trigger_b,
	output wire        osc_input_oe,
	output wire        osc_output_oe,
	output wire        overflow_irq,
	output wire        wake_request,
	output wire        capture_base_valid,
	output wire [15:0] capture_base
);

	// ----------------------------------------
	// Bus, register, prescaler and pin state
	// ----------------------------------------
	reg  [9:0]  addr_ff;
	reg         wr_ff;
	reg  [5:0]  ctl_ff;
	reg  [7:0]  count_low_byte_ff;
	reg  [7:0]  count_high_byte_ff;
	reg         overflow_flag_ff;
	reg         overflow_irq_enable_ff;
	reg  [1:0]  phase_ff;
	reg  [2:0]  pre_ff;
	reg  [2:0]  sync_ff;
	reg  [1:0]  pin_a_ff;
	reg  [1:0]  pin_b_ff;
	reg         prev_edge_ff;
	reg  [15:0] nxt_count;
	reg         nxt_ovf;
	reg         inc;
	reg         pre_tick;
	reg  [2:0]  nxt_pre;

	wire        run_enable          = ctl_ff[`TMR_CTL_RUN];
	wire        clock_source_select = ctl_ff[`TMR_CTL_SRC];
	wire        sync_control        = ctl_ff[`TMR_CTL_SYNC];
	wire        oscillator_enable   = ctl_ff[`TMR_CTL_OSCEN];
	wire [1:0]  prescale_sel = ctl_ff[`TMR_CTL_PS_HI:`TMR_CTL_PS_LO];
	wire [15:0] sixteen_bit_count = {count_high_byte_ff, count_low_byte_ff};
	wire        wr_en = wr_ff;
	wire        take = hsel & hready & htrans[1];
	wire        wr_low;
	wire        wr_high;
	wire        wr_ctl;
	wire        wr_flag;
	wire        wr_ena;
	wire        async_mode;
	wire        trig_hit;
	reg  [31:0] nxt_rdata;

	// Single-cycle, always OKAY slave
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// ----------------------------------------
	// Register decode
	// ----------------------------------------
	// One word per register; byte address is four times the index
	function wr_hit;
		input       wr;
		input [9:0] addr;
		input [9:0] target;
		begin
			wr_hit = wr & (addr == target);
		end
	endfunction

	// Data-phase write strobes, one per register
	assign wr_low  = wr_hit(wr_en, addr_ff, `TMR_ADDR_COUNT_LOW);
	assign wr_high = wr_hit(wr_en, addr_ff, `TMR_ADDR_COUNT_HIGH);
	assign wr_ctl  = wr_hit(wr_en, addr_ff, `TMR_ADDR_CONTROL);
	assign wr_flag = wr_hit(wr_en, addr_ff, `TMR_ADDR_FLAG);
	assign wr_ena  = wr_hit(wr_en, addr_ff, `TMR_ADDR_ENABLE);

	// Unsynchronised counter mode: no time base, no compare reset
	assign async_mode = clock_source_select & sync_control;
	// Compare reset honoured in timer and synchronised counter mode
	assign trig_hit = (compare_trigger_a | compare_trigger_b)
		& ~async_mode;

	// Capture address phase
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			addr_ff <= 10'h000;
			wr_ff   <= 1'b0;
		end
		else
		begin
			addr_ff <= take ? haddr : 10'h000;
			wr_ff   <= take & hwrite;
		end
	end

	// ----------------------------------------
	// Pin synchronisers and phase counter
	// ----------------------------------------
	// Two flops per pin before any logic reads it
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pin_a_ff <= 2'b00;
			pin_b_ff <= 2'b00;
			phase_ff <= 2'b00;
		end
		else
		begin
			pin_a_ff <= {pin_a_ff[0], osc_input_pin};
			pin_b_ff <= {pin_b_ff[0], ext_clock_pin};
			phase_ff <= phase_ff + 2'b01;
		end
	end

	// Both pins idle low, matching the edge detector's reset value
	// Selected external clock, oscillator pin when enabled
	wire ext_clk = oscillator_enable ? pin_a_ff[1] : pin_b_ff[1];

	// Prescaler output bit for the selected ratio
	function pre_out;
		input [2:0] cnt;
		input [1:0] sel;
		begin
			case (sel)
				2'b00:   pre_out = 1'b0;
				2'b01:   pre_out = cnt[0];
				2'b10:   pre_out = cnt[1];
				default: pre_out = cnt[2];
			endcase
		end
	endfunction

	// ----------------------------------------
	// Prescaler and count datapath
	// ----------------------------------------
	always @*
	begin
		pre_tick = 1'b0;
		nxt_pre  = pre_ff;
		inc      = 1'b0;
		// Rising edge of external clock advances prescaler
		if (clock_source_select && ext_clk && !prev_edge_ff)
		begin
			nxt_pre = pre_ff + 3'b001;
			// Prescaler output rises: ratio 1:1 passes every edge
			if (prescale_sel == 2'b00)
				pre_tick = 1'b1;
			else
				pre_tick = pre_out(nxt_pre, prescale_sel)
					& ~pre_out(pre_ff, prescale_sel);
		end
		if (wr_low || wr_high)
			nxt_pre = 3'b000;
		if (!run_enable)
			inc = 1'b0;
		else if (!clock_source_select)
			inc = (phase_ff == 2'b11);
		else if (sync_control)
			inc = pre_tick;
		else
			// Sync path: prescaler output sampled on phase 2 and 4
			inc = sync_ff[2] & ~sleep_mode;
	end

	// Synchronised tick pipeline (delay after qualifying edge)
	// Stage 0 holds a tick until an odd phase passes it on
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pre_ff       <= 3'b000;
			prev_edge_ff <= 1'b0;
			sync_ff      <= 3'b000;
		end
		else
		begin
			pre_ff       <= nxt_pre;
			prev_edge_ff <= ext_clk;
			sync_ff[0]   <= pre_tick | (sync_ff[0] & ~phase_ff[0]);
			sync_ff[1]   <= phase_ff[0] ? sync_ff[0] : 1'b0;
			sync_ff[2]   <= sync_ff[1];
		end
	end

	// Next count: write wins over trigger, trigger beats increment
	always @*
	begin
		nxt_count = sixteen_bit_count;
		nxt_ovf   = 1'b0;
		if (inc)
		begin
			nxt_count = sixteen_bit_count + 16'h0001;
			nxt_ovf   = (sixteen_bit_count == `TMR_MAX_COUNT);
		end
		if (trig_hit)
		begin
			nxt_count = `TMR_ZERO_COUNT;
			nxt_ovf   = 1'b0;
		end
		// A byte write replaces only its own byte, over any trigger
		if (wr_low)
			nxt_count[7:0] = hwdata[7:0];
		if (wr_high)
			nxt_count[15:8] = hwdata[7:0];
	end

	// Count registers; all bus reads see whole settled bytes
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			count_low_byte_ff  <= 8'h00;
			count_high_byte_ff <= 8'h00;
		end
		else
		begin
			count_low_byte_ff  <= nxt_count[7:0];
			count_high_byte_ff <= nxt_count[15:8];
		end
	end

	// ----------------------------------------
	// Control, flag and enable registers
	// ----------------------------------------
	// Control reset only by power-on reset
	// Bus reset leaves it alone, so the setup outlives it
	always @(posedge hclk or negedge por_resetn)
	begin
		if (!por_resetn)
			ctl_ff <= `TMR_CTL_RESET;
		else if (wr_ctl)
			ctl_ff <= hwdata[5:0];
	end

	// Flag: set wins over software clear
	// Enable masks only the request, never the flag
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			overflow_flag_ff       <= 1'b0;
			overflow_irq_enable_ff <= 1'b0;
		end
		else
		begin
			if (nxt_ovf)
				overflow_flag_ff <= 1'b1;
			else if (wr_flag)
				overflow_flag_ff <= hwdata[`TMR_OVF_BIT];
			if (wr_ena)
				overflow_irq_enable_ff <= hwdata[`TMR_IE_BIT];
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign overflow_irq = overflow_flag_ff & overflow_irq_enable_ff;
	assign wake_request = overflow_irq & async_mode;
	assign osc_input_oe  = 1'b0;
	assign osc_output_oe = 1'b0;
	assign capture_base = sixteen_bit_count;
	assign capture_base_valid = ~async_mode;

	// ----------------------------------------
	// Bus read path
	// ----------------------------------------

	// Read word for the register addressed in this address phase
	always @*
	begin
		nxt_rdata = 32'h00000000;
		case (haddr)
			`TMR_ADDR_COUNT_LOW:
				nxt_rdata[7:0] = nxt_count[7:0];
			`TMR_ADDR_COUNT_HIGH:
				nxt_rdata[7:0] = nxt_count[15:8];
			`TMR_ADDR_CONTROL:
				nxt_rdata[5:0] = ctl_ff;
			`TMR_ADDR_FLAG:
				nxt_rdata[`TMR_OVF_BIT] = overflow_flag_ff;
			`TMR_ADDR_ENABLE:
				nxt_rdata[`TMR_IE_BIT] = overflow_irq_enable_ff;
			default:
				nxt_rdata = 32'h00000000;
		endcase
	end

	// Read data registered for the data phase
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h00000000;
		else if (take && !hwrite)
			hrdata <= nxt_rdata;
	end

endmodule // tmr_timer1

// File: verif/tmr_timer1_asserts.sv
`timescale 1ns/100ps
module tmr_timer1_asserts
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic        hready,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        osc_input_oe,
	input wire logic        osc_output_oe,
	input wire logic        overflow_irq,
	input wire logic        wake_request,
	input wire logic        capture_base_valid,
	input wire logic [15:0] capture_base,
	input wire logic        compare_trigger_a,
	input wire logic        compare_trigger_b
);
	logic wr_ff;
	// Marks the data phase of a bus write
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			wr_ff <= 1'b0;
		else
			wr_ff <= hsel && hready && htrans[1] && hwrite;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence trig_s;
		(compare_trigger_a || compare_trigger_b) && capture_base_valid && !wr_ff;
	endsequence
	sequence zero_s;
		##[1:2] capture_base == 16'h0000;
	endsequence
	// ---------
	// Checks
	// ---------
	bus_ready_a: assert property (hreadyout) else $error("wait state");
	bus_okay_a: assert property (!hresp) else $error("error response");
	pins_input_a: assert property (!osc_input_oe && !osc_output_oe)
		else $error("oscillator pin driven");
	wake_async_a: assert property (wake_request |-> overflow_irq
		&& !capture_base_valid) else $error("stray wake");
	count_step_a: assert property ($changed(capture_base) && !$past(wr_ff)
		|-> capture_base == $past(capture_base) + 16'h0001
		|| capture_base == 16'h0000) else $error("count jumped");
	irq_fall_a: assert property ($fell(overflow_irq) |-> $past(wr_ff))
		else $error("irq dropped alone");
	irq_rise_a: assert property ($rose(overflow_irq) |-> $past(wr_ff)
		|| capture_base <= 16'h0003) else $error("irq without wrap");
	trig_clear_a: assert property (trig_s |-> zero_s)
		else $error("trigger did not clear");
endmodule // tmr_timer1_asserts

bind tmr_timer1 tmr_timer1_asserts i_tmr_timer1_asserts (.hclk, .hresetn,
	.hsel, .hready, .htrans, .hwrite, .hreadyout, .hresp, .osc_input_oe,
	.osc_output_oe, .overflow_irq, .wake_request, .capture_base_valid,
	.capture_base, .compare_trigger_a, .compare_trigger_b);

// File: verif/tmr_ext_clk.sv
`timescale 1ns/100ps
module tmr_ext_clk
#(
	parameter real HALF = 53.3
)
(
	en,
	pin
);
	input  wire en;
	output reg  pin;
	// Toggles while enabled, rests low between bursts
	initial
	begin
		pin = 1'b0;
		forever
		begin
			#(HALF);
			pin = en ? ~pin : 1'b0;
		end
	end
endmodule // tmr_ext_clk

// File: verif/tmr_timer1_tb.sv
`timescale 1ns/100ps
`include "tmr_regs.vh"
module tmr_timer1_tb;
	localparam LO = `TMR_ADDR_COUNT_LOW, HI = `TMR_ADDR_COUNT_HIGH;
	localparam CT = `TMR_ADDR_CONTROL, FL = `TMR_ADDR_FLAG;
	localparam [143:0] TAB = {16'h0310, 16'h1308, 16'h2304, 16'h3302,
		16'h0200, 16'h0B10, 16'h0710, 16'h8300, 16'h8710};
	reg         hclk = 1'b0, hresetn = 1'b0, por_resetn = 1'b0;
	reg         hsel = 1'b0, hwrite = 1'b0, sleep_mode = 1'b0;
	reg         compare_trigger_a = 1'b0, compare_trigger_b = 1'b0;
	reg         en_x = 1'b0, en_o = 1'b0;
	reg  [9:0]  haddr = 10'h000;
	reg  [7:0]  q;
	reg  [1:0]  htrans = 2'b00;
	reg  [31:0] hwdata = 32'h00000000;
	reg  [15:0] e;
	wire        hreadyout, overflow_irq, capture_base_valid;
	wire        ext_clock_pin, osc_input_pin;
	wire        wake_request;
	wire [31:0] hrdata;
	integer     errors = 0, checks = 0, i;
	tmr_timer1 i_tmr_timer1
	(
		.hclk, .hresetn, .por_resetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'b010), .hwdata, .hready(hreadyout), .hreadyout, .hresp(),
		.hrdata, .osc_input_pin, .ext_clock_pin, .sleep_mode,
		.compare_trigger_a, .compare_trigger_b, .osc_input_oe(),
		.osc_output_oe(), .overflow_irq, .wake_request,
		.capture_base_valid, .capture_base()
	);
	tmr_ext_clk #(.HALF(53.3)) i_tmr_ext_clk_x (.en(en_x), .pin(ext_clock_pin));
	tmr_ext_clk #(.HALF(71.7)) i_tmr_ext_clk_o (.en(en_o), .pin(osc_input_pin));
	// Clock
	initial
	begin
		forever #5 hclk = ~hclk;
	end
	// ---------
	// Tasks
	// ---------
	task cyc(input integer n);
		repeat (n) @(posedge hclk);
	endtask
	task bus(input [9:0] a, input w, input [7:0] d);
		begin
			hsel <= 1'b1;
			haddr <= a;
			hwrite <= w;
			htrans <= 2'b10;
			@(posedge hclk);
			while (hreadyout !== 1'b1) @(posedge hclk);
			hsel <= 1'b0;
			htrans <= 2'b00;
			hwdata <= {24'h000000, d};
			@(posedge hclk);
			while (hreadyout !== 1'b1) @(posedge hclk);
			q = hrdata[7:0];
		end
	endtask
	task chk(input [7:0] g, input [7:0] x);
		begin
			checks = checks + 1;
			if (g !== x)
			begin
				errors = errors + 1;
				$display("BAD %0t got %h exp %h", $time, g, x);
			end
		end
	endtask
	// Sixteen rises on the chosen pin, both sources running
	task burst(input o);
		begin
			en_x <= 1'b1;
			en_o <= 1'b1;
			if (o)
				repeat (16) @(posedge osc_input_pin);
			else
				repeat (16) @(posedge ext_clock_pin);
			en_x <= 1'b0;
			en_o <= 1'b0;
			cyc(12);
		end
	endtask
	task give_verdict;
		begin
			if (errors == 0 && checks > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	// Hang guard
	initial
	begin
		#100000;
		errors = errors + 1;
		give_verdict;
	end
	// ---------
	// Tests
	// ---------
	initial
	begin
		cyc(3);
		hresetn <= 1'b1;
		por_resetn <= 1'b1;
		cyc(1);
		bus(CT, 1'b0, 8'h00);
		chk(q, 8'h00);
		bus(10'h01C, 1'b0, 8'h00);
		chk(q, 8'h00);
		bus(LO, 1'b1, 8'hF0);
		bus(HI, 1'b1, 8'hFF);
		bus(CT, 1'b1, 8'h05);
		cyc(200);
		bus(CT, 1'b1, 8'h00);
		bus(HI, 1'b0, 8'h00);
		chk(q, 8'h00);
		bus(FL, 1'b0, 8'h00);
		chk(q, 8'h01);
		chk({7'h00, overflow_irq}, 8'h00);
		bus(`TMR_ADDR_ENABLE, 1'b1, 8'h01);
		cyc(1);
		chk({7'h00, overflow_irq}, 8'h01);
		// Free-running read: high, low, high, reread on a carry
		bus(LO, 1'b1, 8'hFF);
		bus(HI, 1'b1, 8'h12);
		bus(CT, 1'b1, 8'h01);
		bus(HI, 1'b0, 8'h00);
		e[15:8] = q;
		bus(LO, 1'b0, 8'h00);
		e[7:0] = q;
		bus(HI, 1'b0, 8'h00);
		if (q !== e[15:8])
		begin
			bus(HI, 1'b0, 8'h00);
			e[15:8] = q;
			bus(LO, 1'b0, 8'h00);
			e[7:0] = q;
		end
		chk({7'h00, e >= 16'h12FF && e <= 16'h1310}, 8'h01);
		// Source, prescale, run, sleep and sync cases from the table
		for (i = 0; i < 9; i = i + 1)
		begin
			e = TAB[16*i +: 16];
			bus(CT, 1'b1, 8'h00);
			bus(LO, 1'b1, 8'h00);
			bus(HI, 1'b1, 8'h00);
			sleep_mode <= e[15];
			bus(CT, 1'b1, e[15:8] & 8'h3F);
			burst(e[11]);
			chk({7'h00, capture_base_valid}, {7'h00, ~&e[10:9]});
			chk({7'h00, wake_request}, {7'h00, &e[10:9]});
			bus(LO, 1'b0, 8'h00);
			chk(q, e[7:0]);
		end
		sleep_mode <= 1'b0;
		bus(FL, 1'b1, 8'h00);
		cyc(1);
		chk({7'h00, overflow_irq}, 8'h00);
		// Each compare unit in turn clears a running count
		for (i = 0; i < 2; i = i + 1)
		begin
			bus(HI, 1'b1, 8'h50);
			bus(CT, 1'b1, {5'h00, i[0], 2'b01});
			cyc(3);
			{compare_trigger_b, compare_trigger_a} <= i[1:0] + 2'b01;
			cyc(1);
			{compare_trigger_b, compare_trigger_a} <= 2'b00;
			bus(CT, 1'b1, 8'h00);
			bus(HI, 1'b0, 8'h00);
			chk(q, 8'h00);
			bus(FL, 1'b0, 8'h00);
			chk(q, 8'h00);
		end
		// Bus reset keeps control, power-on reset clears it
		bus(CT, 1'b1, 8'h30);
		hresetn <= 1'b0;
		cyc(2);
		hresetn <= 1'b1;
		bus(CT, 1'b0, 8'h00);
		chk(q, 8'h30);
		por_resetn <= 1'b0;
		cyc(2);
		por_resetn <= 1'b1;
		bus(CT, 1'b0, 8'h00);
		chk(q, 8'h00);
		give_verdict;
	end
endmodule // tmr_timer1_tb
